// ===== rtl/tkd_defines.svh
`ifndef TKD_DEFINES_SVH
`define TKD_DEFINES_SVH

// ----------------------------------------------------------------
// Geometry and widths
// ----------------------------------------------------------------
`define TKD_NUM_KEYS 4
`define TKD_SIG_W 12
`define TKD_TMR_W 13

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TKD_CLK_PERIOD_NS 10
`define TKD_TICK_PERIOD_NS 10000000
`define TKD_TICK_CYCLES (`TKD_TICK_PERIOD_NS / `TKD_CLK_PERIOD_NS)
`define TKD_TICKS_PER_S (1000000000 / `TKD_TICK_PERIOD_NS)
`define TKD_CAL_TIME_MS 1000
`define TKD_CAL_TICKS ((`TKD_CAL_TIME_MS * 1000000) / `TKD_TICK_PERIOD_NS)
`define TKD_TO_SHORT_S 10
`define TKD_TO_LONG_S 60
`define TKD_TO_SHORT_TICKS (`TKD_TO_SHORT_S * `TKD_TICKS_PER_S)
`define TKD_TO_LONG_TICKS (`TKD_TO_LONG_S * `TKD_TICKS_PER_S)
`define TKD_DRIFT_UP_MS 100
`define TKD_DRIFT_DN_MS 1000
`define TKD_DRIFT_UP_TICKS ((`TKD_DRIFT_UP_MS * 1000000) / `TKD_TICK_PERIOD_NS)
`define TKD_DRIFT_DN_TICKS ((`TKD_DRIFT_DN_MS * 1000000) / `TKD_TICK_PERIOD_NS)

// ----------------------------------------------------------------
// Detection figures and reset values
// ----------------------------------------------------------------
`define TKD_THRESH 4
`define TKD_HYST_PCT 25
`define TKD_INTEG_LIMIT 3
`define TKD_PIN_RESET 1'h1

`endif

// ===== rtl/tkd_key.sv
`timescale 1ns/1ps
`default_nettype none
`include "tkd_defines.svh"

module tkd_key #(
    parameter int unsigned SIG_W     = `TKD_SIG_W,
    parameter int unsigned TMR_W     = `TKD_TMR_W,
    parameter int unsigned INTEG_LIM = `TKD_INTEG_LIMIT
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_sync_b,
    input  wire logic             cal_active,
    input  wire logic             smp_valid,
    input  wire logic [SIG_W-1:0] smp_val,
    input  wire logic             tick,
    input  wire logic             drift_up_tick,
    input  wire logic             drift_dn_tick,
    input  wire logic [TMR_W-1:0] to_limit,
    input  wire logic             requal,
    output logic                  det,
    output logic                  confirm,
    output logic                  cal_ok
);
    import tkd_pkg::*;

    localparam int unsigned IW = $clog2(INTEG_LIM + 1);

    logic [SIG_W-1:0] ref_lvl;
    logic [SIG_W-1:0] last_smp;
    logic [SIG_W-1:0] thr_lvl;
    logic [SIG_W+6:0] hyst_w;
    logic [SIG_W-1:0] hyst;
    logic [IW-1:0]    integ;
    logic [TMR_W-1:0] on_tmr;
    logic             recal_pend;
    logic             load;
    logic             below;
    logic             release_c;
    logic             timeout;

    // [RULE5] [RULE19] Threshold follows reference.
    always_comb begin
        thr_lvl = (ref_lvl > SIG_W'(`TKD_THRESH)) ? ref_lvl - SIG_W'(`TKD_THRESH) : '0;
        hyst_w = ({7'h00, ref_lvl - thr_lvl} * 7'(`TKD_HYST_PCT)) / 7'h64;
        hyst = hyst_w[SIG_W-1:0];
        // [RULE6] Only a falling signal detects.
        below = smp_val < thr_lvl;
        // [RULE7] Release above threshold plus hysteresis.
        release_c = {1'b0, smp_val} > ({1'b0, thr_lvl} + {1'b0, hyst});
        load = smp_valid && (cal_active || recal_pend);
        timeout = det && (on_tmr >= to_limit);
    end

    // [RULE18] Reference captured from burst length.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ref_lvl <= '0;
        end else if (load) begin
            ref_lvl <= smp_val;
        // [RULE2] [RULE3] [RULE4] Slow asymmetric drift only without detection.
        end else if (!det && !recal_pend && !cal_active) begin
            if (last_smp > ref_lvl && drift_up_tick) begin
                ref_lvl <= ref_lvl + 1'b1;
            end else if (last_smp < ref_lvl && drift_dn_tick) begin
                ref_lvl <= ref_lvl - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            last_smp <= '0;
            cal_ok <= 1'b0;
        end else if (smp_valid) begin
            last_smp <= smp_val;
            cal_ok <= cal_ok | cal_active;
        end
    end

    // [RULE12] [RULE13] [RULE14] Integrate three consecutive samples.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            integ <= '0;
            det <= 1'b0;
            confirm <= 1'b0;
        end else begin
            confirm <= 1'b0;
            if (cal_active || recal_pend || requal || timeout) begin
                integ <= '0;
                det <= 1'b0;
            end else if (smp_valid) begin
                if (det) begin
                    integ <= '0;
                    det <= !release_c;
                end else if (!below) begin
                    integ <= '0;
                end else if (integ == IW'(INTEG_LIM - 1)) begin
                    integ <= '0;
                    det <= 1'b1;
                    confirm <= 1'b1;
                end else begin
                    integ <= integ + 1'b1;
                end
            end
        end
    end

    // [RULE8] [RULE9] [RULE10] Own timer, own recalibration.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            on_tmr <= '0;
            recal_pend <= 1'b0;
        end else begin
            on_tmr <= (!det || timeout) ? '0 : on_tmr + TMR_W'(tick && on_tmr != '1);
            if (timeout) begin
                recal_pend <= 1'b1;
            end else if (smp_valid) begin
                recal_pend <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_b);

    a_ref_frozen: assert property (det |=> ref_lvl == $past(ref_lvl)) // RULE2
        else $error("reference moved during detection");
    a_ref_slew: assert property (!load |=> ref_lvl == $past(ref_lvl) || ref_lvl == $past(ref_lvl) + 1 // RULE3
        || ref_lvl + 1 == $past(ref_lvl)) else $error("reference stepped by more than one");
    a_drift_up: assert property (!load && !det && !recal_pend && !cal_active // RULE4
        && last_smp > ref_lvl && drift_up_tick |=> ref_lvl == $past(ref_lvl) + 1)
        else $error("reference did not follow rising signal");
    a_no_rise_det: assert property (smp_valid && !below |=> !confirm) // RULE6
        else $error("detection on a non-falling sample");
    a_hyst_hold: assert property (det && smp_valid && !release_c && !timeout && !requal // RULE7
        && !cal_active && !recal_pend |=> det) else $error("dropped out inside hysteresis");
    a_timeout_recal: assert property (timeout |=> !det && recal_pend ##1 !det) // RULE8
        else $error("timeout did not recalibrate");
    a_integ_clear: assert property (smp_valid && !det && !below |=> integ == '0) // RULE13
        else $error("integrator not cleared");
    a_integ_three: assert property (confirm |-> $past(integ) == IW'(INTEG_LIM - 1) // RULE14
        && $past(smp_valid) && $past(below)) else $error("confirmed before full count");

    c_confirm: cover property (confirm);
    c_timeout: cover property (timeout);

endmodule // tkd_key
`default_nettype wire

// ===== rtl/tkd_pkg.sv
package tkd_pkg;

    typedef enum logic [1:0] {
        SC_REQ  = 2'b01,
        SC_WAIT = 2'b10
    } tkd_scan_t;

    typedef enum logic [1:0] {
        CL_CAL = 2'b01,
        CL_RUN = 2'b10
    } tkd_cal_t;

endpackage

// ===== rtl/tkd_top.sv
// Notes on behaviour
// [RULE1] After reset, sample every key and set its reference for about one second.
// [RULE2] Reference drifts toward the raw signal only while the key is not detecting.
// [RULE3] Reference moves one count per drift step; threshold and hysteresis follow.
// [RULE4] Reference follows a rising signal faster than a falling one.
// [RULE5] Threshold is a fixed offset below the current reference, always recomputed.
// [RULE6] Only a signal decrease counts as touch; increases never detect.
// [RULE7] Detection drops only when signal exceeds threshold plus a quarter of the offset.
// [RULE8] Each key times its continuous detection and recalibrates past the limit.
// [RULE9] After timeout recalibration the key detects normally from its new reference.
// [RULE10] A timeout on one key leaves every other key untouched; here a reported key's timeout clears det on suppressed keys via requal_v.
// [RULE11] Timeout select low gives ten seconds, high gives sixty, for all keys.
// [RULE12] Each below-threshold sample advances the key's integrator until its limit.
// [RULE13] Any non-detecting sample before the limit clears the integrator at once.
// [RULE14] Three consecutive detecting samples confirm a key's detection.
// [RULE15] Rollover select low reports one key; high reports at most two.
// [RULE16] Four active-high outputs, each high while its key is confirmed.
// [RULE17] Row lines are always driven, except while in reset.
// [RULE18] Touch is judged from burst length against the calibrated reference.
// [RULE19] Threshold offset is four signal counts below reference.
// [RULE20] In two-key mode only the first two confirmed keys are reported.
// [RULE21] All outputs stay low until power-up calibration is complete.
// [RULE22] A suppressed key may report only after a reported key releases and reconfirms.
`timescale 1ns/1ps
`default_nettype none
`include "tkd_defines.svh"

module tkd_top #(
    parameter int unsigned NKEY           = `TKD_NUM_KEYS,
    parameter int unsigned SIG_W          = `TKD_SIG_W,
    parameter int unsigned TMR_W          = `TKD_TMR_W,
    parameter int unsigned TICK_CYC       = `TKD_TICK_CYCLES,
    parameter int unsigned CAL_TICKS      = `TKD_CAL_TICKS,
    parameter int unsigned TO_SHORT_TICKS = `TKD_TO_SHORT_TICKS,
    parameter int unsigned TO_LONG_TICKS  = `TKD_TO_LONG_TICKS,
    parameter int unsigned DRIFT_UP_TICKS = `TKD_DRIFT_UP_TICKS,
    parameter int unsigned DRIFT_DN_TICKS = `TKD_DRIFT_DN_TICKS
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_b,
    input  wire logic                    rollover_select_pin,
    input  wire logic                    timeout_select_pin,
    input  wire logic                    burst_done,
    input  wire logic [SIG_W-1:0]        burst_len,
    output logic                         burst_req,
    output logic [$clog2(NKEY)-1:0]      burst_key,
    output logic [NKEY-1:0]              row_drive,
    output logic [NKEY-1:0]              row_oe_b,
    output logic [NKEY-1:0]              touch_out,
    output logic                         cal_done
);
    import tkd_pkg::*;

    localparam int unsigned KW = $clog2(NKEY);
    localparam int unsigned TW = $clog2(TICK_CYC + 1);
    localparam int unsigned CW = $clog2(CAL_TICKS + 1);
    localparam int unsigned UW = $clog2(DRIFT_UP_TICKS + 1);
    localparam int unsigned DW = $clog2(DRIFT_DN_TICKS + 1);

    logic            rst_meta;
    logic            rst_sync_b;
    logic            roll_two;
    logic            to_long;
    logic [TW-1:0]   tick_cnt;
    logic            tick;
    logic [UW-1:0]   up_cnt;
    logic [DW-1:0]   dn_cnt;
    logic            drift_up_tick;
    logic            drift_dn_tick;
    logic [CW-1:0]   cal_ticks;
    tkd_cal_t        cal_st;
    tkd_scan_t       scan_st;
    logic [NKEY-1:0] smp_valid;
    logic [NKEY-1:0] det_v;
    logic [NKEY-1:0] confirm_v;
    logic [NKEY-1:0] cal_ok_v;
    logic [NKEY-1:0] requal_v;
    logic [NKEY-1:0] grant;
    logic [NKEY-1:0] next_grant;
    logic [2:0]      used;
    logic [2:0]      lim;
    logic [TMR_W-1:0] to_limit;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // Option pins
    // ----------------------------------------------------------------
    // Pins are sampled every cycle, so a jumper change takes effect live.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            roll_two <= `TKD_PIN_RESET;
            to_long <= `TKD_PIN_RESET;
        end else begin
            roll_two <= rollover_select_pin;
            to_long <= timeout_select_pin;
        end
    end

    // [RULE11] Timeout limit from select pin.
    assign to_limit = to_long ? TMR_W'(TO_LONG_TICKS) : TMR_W'(TO_SHORT_TICKS);

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    // All long intervals count coarse ticks so the timers stay narrow.
    assign tick = tick_cnt == TW'(TICK_CYC - 1);
    assign drift_up_tick = tick && up_cnt == UW'(DRIFT_UP_TICKS - 1);
    assign drift_dn_tick = tick && dn_cnt == DW'(DRIFT_DN_TICKS - 1);

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
        end
    end

    // [RULE4] Rising drift steps ten times as often.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            up_cnt <= '0;
            dn_cnt <= '0;
        end else if (tick) begin
            up_cnt <= drift_up_tick ? '0 : up_cnt + 1'b1;
            dn_cnt <= drift_dn_tick ? '0 : dn_cnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Power-up calibration
    // ----------------------------------------------------------------
    // [RULE1] Calibrate for the full window and until every key is seen.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cal_ticks <= '0;
            cal_st <= CL_CAL;
            cal_done <= 1'b0;
        end else begin
            if (tick && cal_ticks != CW'(CAL_TICKS)) begin
                cal_ticks <= cal_ticks + 1'b1;
            end
            case (cal_st)
                CL_CAL: begin
                    if (cal_ticks == CW'(CAL_TICKS) && &cal_ok_v) begin
                        cal_st <= CL_RUN;
                        cal_done <= 1'b1;
                    end
                end
                CL_RUN: begin
                    cal_done <= 1'b1;
                end
                default: begin
                    cal_st <= CL_CAL;
                    cal_done <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Key scan and row drive
    // ----------------------------------------------------------------
    // [RULE17] Rows leave high impedance at the first edge after reset.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            row_oe_b <= '1;
        end else begin
            row_oe_b <= '0;
        end
    end

    // One burst is outstanding at a time; the shared sampling capacitor forbids overlap.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            scan_st <= SC_REQ;
            burst_req <= 1'b0;
            burst_key <= '0;
            row_drive <= '0;
        end else begin
            burst_req <= 1'b0;
            case (scan_st)
                SC_REQ: begin
                    burst_req <= 1'b1;
                    row_drive <= NKEY'(1) << burst_key;
                    scan_st <= SC_WAIT;
                end
                SC_WAIT: begin
                    if (burst_done) begin
                        row_drive <= '0;
                        burst_key <= (burst_key == KW'(NKEY - 1)) ? '0 : burst_key + 1'b1;
                        scan_st <= SC_REQ;
                    end
                end
                default: begin
                    row_drive <= '0;
                    scan_st <= SC_REQ;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Per-key decision
    // ----------------------------------------------------------------
    // [RULE10] Independent channel per key.
    for (genvar k = 0; k < NKEY; k++) begin : g_key
        // [RULE18] Route each burst to its own key.
        assign smp_valid[k] = (scan_st == SC_WAIT) && burst_done && burst_key == KW'(k);

        tkd_key #(
            .SIG_W     (SIG_W),
            .TMR_W     (TMR_W),
            .INTEG_LIM (`TKD_INTEG_LIMIT)
        ) u_key (
            .clk_sys       (clk_sys),
            .rst_sync_b    (rst_sync_b),
            .cal_active    (cal_st == CL_CAL),
            .smp_valid     (smp_valid[k]),
            .smp_val       (burst_len),
            .tick          (tick),
            .drift_up_tick (drift_up_tick),
            .drift_dn_tick (drift_dn_tick),
            .to_limit      (to_limit),
            .requal        (requal_v[k]),
            .det           (det_v[k]),
            .confirm       (confirm_v[k]),
            .cal_ok        (cal_ok_v[k])
        );
    end

    // ----------------------------------------------------------------
    // Rollover arbitration
    // ----------------------------------------------------------------
    // [RULE15] [RULE20] First confirmed keys take the free slots.
    always_comb begin
        lim = roll_two ? 3'h2 : 3'h1;
        next_grant = grant & det_v;
        used = 3'($countones(next_grant));
        for (int k = 0; k < NKEY; k++) begin
            if (confirm_v[k] && !next_grant[k] && used < lim) begin
                next_grant[k] = 1'b1;
                used = used + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            grant <= '0;
        end else begin
            grant <= next_grant;
        end
    end

    // [RULE22] Suppressed keys must integrate again once a slot frees.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            requal_v <= '0;
        end else begin
            requal_v <= (|(grant & ~det_v)) ? (det_v & ~next_grant) : '0;
        end
    end

    // [RULE16] [RULE21] Outputs follow granted keys after calibration.
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            touch_out <= '0;
        end else begin
            touch_out <= next_grant & {NKEY{cal_done}};
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_b);

    a_cal_gate: assert property (!cal_done |=> touch_out == '0) // RULE21
        else $error("output high before calibration");
    a_cal_window: assert property ($rose(cal_done) |-> cal_ticks == CW'(CAL_TICKS) && &cal_ok_v) // RULE1
        else $error("calibration ended early");
    a_one_key: assert property (!$past(roll_two) && (touch_out & ~$past(touch_out)) != '0 // RULE15
        |-> $countones(touch_out) == 1) else $error("second key reported in one-key mode");
    a_two_cap: assert property ($countones(touch_out) <= 2) // RULE20
        else $error("more than two keys reported");
    a_out_det: assert property ((touch_out & ~$past(det_v)) == '0) // RULE16
        else $error("output high without detection");
    a_rows_on: assert property ($past(rst_sync_b) |-> row_oe_b == '0) // RULE17
        else $error("row lines released");
    a_requal: assert property ((|(grant & ~det_v)) && (det_v & ~next_grant) != '0 // RULE22
        |=> requal_v != '0 ##1 (det_v & $past(requal_v)) == '0)
        else $error("suppressed key not requalified");
    a_scan_one: assert property (burst_req |-> ##[1:2] $onehot(row_drive)) // RULE18
        else $error("no single row selected for burst");

    c_cal_done: cover property ($rose(cal_done));
    c_two_keys: cover property ($countones(touch_out) == 2);
    c_requal: cover property (requal_v != '0);

endmodule // tkd_top
`default_nettype wire

// ===== verif/tkd_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
module tkd_fe_model (
    input  wire logic        clk_sys,
    input  wire logic        burst_req,
    input  wire logic [1:0]  burst_key,
    input  wire logic [47:0] key_val,
    output logic             burst_done,
    output logic [11:0]      burst_len
);
    logic [1:0] wait_cnt;
    logic       busy;
    initial begin
        busy = 1'b0;
        wait_cnt = 2'h0;
        burst_done = 1'b0;
        burst_len = 12'h000;
    end
    // The key index sets the burst delay, so prompt and slow answers both occur.
    // Outside a pulse the length toggles each cycle so a stale value is never read as valid.
    // burst length per key
    always @(posedge clk_sys) begin
        burst_done <= 1'b0;
        burst_len <= ~burst_len;
        if (burst_req) begin
            busy <= 1'b1;
            wait_cnt <= burst_key;
        end else if (busy && wait_cnt == 2'h0) begin
            busy <= 1'b0;
            burst_done <= 1'b1;
            burst_len <= key_val[burst_key*12 +: 12];
        end else if (busy) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
    end
endmodule // tkd_fe_model
`default_nettype wire

// ===== verif/touch_key_decision_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module touch_key_decision_logic_test;
    logic        clk_sys, rst_b, ro_pin, to_pin, burst_done, burst_req, cal_done;
    logic [47:0] key_val;
    logic [11:0] burst_len;
    logic [1:0]  burst_key;
    logic [3:0]  row_drive, row_oe_b, touch_out;
    int          mismatches = 0;
    int          cmp_count = 0;

    tkd_top #(.TICK_CYC(4), .CAL_TICKS(3), .TO_SHORT_TICKS(40), .TO_LONG_TICKS(200),
              .DRIFT_DN_TICKS(20000)) i_tkd_top (
        .clk_sys(clk_sys), .rst_b(rst_b), .rollover_select_pin(ro_pin), .timeout_select_pin(to_pin),
        .burst_done(burst_done), .burst_len(burst_len), .burst_req(burst_req), .burst_key(burst_key),
        .row_drive(row_drive), .row_oe_b(row_oe_b), .touch_out(touch_out), .cal_done(cal_done));
    tkd_fe_model i_tkd_fe_model (.clk_sys(clk_sys), .burst_req(burst_req), .burst_key(burst_key),
        .key_val(key_val), .burst_done(burst_done), .burst_len(burst_len));

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic set_keys(input logic [3:0] m, input logic [11:0] v);
        @(posedge clk_sys);
        for (int k = 0; k < 4; k++) if (m[k]) key_val[k*12 +: 12] <= v;
    endtask
    task automatic wait_out(input logic [3:0] exp, input int lim);
        int n;
        n = 0;
        step(1);
        while (touch_out !== exp && n < lim) begin
            step(1);
            n++;
        end
        check("touch_out", touch_out, exp);
        if (touch_out !== exp) wrap_up();
    endtask
    // Passes only if the outputs keep their value for the whole span.
    task automatic hold(input logic [3:0] exp, input int lim);
        int n;
        n = 0;
        step(1);
        while (touch_out === exp && n < lim) begin
            step(1);
            n++;
        end
        check("touch_out held", touch_out, exp);
    endtask
    task automatic wait_smp(input logic [1:0] k, input int cnt);
        int n;
        n = 0;
        while (cnt > 0 && n < 500) begin
            step(1);
            n++;
            if (burst_done === 1'b1 && burst_key === k) begin
                cnt--;
                check("row_drive", row_drive, 12'h001 << k);
            end
        end
        if (cnt > 0) check("sample wait", 1'b0, 1'b1);
        if (cnt > 0) wrap_up();
    endtask

    task automatic t_power_up();
        int n;
        n = 0;
        while (cal_done !== 1'b1 && n < 300) begin
            step(1);
            n++;
            if (touch_out !== 4'h0) check("touch_out in cal", touch_out, 4'h0);
        end
        check("cal_done", cal_done, 1'b1);
        check("cal length", n >= 12, 1'b1);
        check("row_oe_b", row_oe_b, 4'h0);
        $display("done power_up");
    endtask
    task automatic t_integrate();
        set_keys(4'h1, 12'h3E4);
        wait_smp(0, 4);
        check("touch at offset", touch_out, 4'h0);
        set_keys(4'h1, 12'h3E3);
        wait_smp(0, 2);
        set_keys(4'h1, 12'h3E8);
        wait_smp(0, 1);
        set_keys(4'h1, 12'h3E3);
        wait_smp(0, 2);
        step(3);
        check("touch after restart", touch_out, 4'h0);
        wait_out(4'h1, 40);
        set_keys(4'h1, 12'h3E5);
        wait_smp(0, 3);
        step(3);
        check("touch inside band", touch_out, 4'h1);
        set_keys(4'h1, 12'h3E6);
        wait_out(4'h0, 40);
        set_keys(4'h1, 12'h3E8);
        $display("done integrate");
    endtask
    task automatic t_drift();
        set_keys(4'h2, 12'h3ED);
        hold(4'h0, 300);
        set_keys(4'h2, 12'h3E8);
        wait_out(4'h2, 80);
        set_keys(4'h2, 12'h3ED);
        wait_out(4'h0, 40);
        $display("done drift");
    endtask
    task automatic t_rollover();
        set_keys(4'h3, 12'h384);
        wait_out(4'h3, 100);
        set_keys(4'h4, 12'h384);
        hold(4'h3, 80);
        set_keys(4'h1, 12'h3E8);
        wait_out(4'h6, 100);
        set_keys(4'h2, 12'h3ED);
        set_keys(4'h4, 12'h3E8);
        wait_out(4'h0, 60);
        @(posedge clk_sys) ro_pin <= 1'b0;
        set_keys(4'h4, 12'h384);
        wait_out(4'h4, 80);
        set_keys(4'h8, 12'h384);
        hold(4'h4, 80);
        set_keys(4'hC, 12'h3E8);
        wait_out(4'h0, 60);
        @(posedge clk_sys) ro_pin <= 1'b1;
        $display("done rollover");
    endtask
    task automatic t_timeout();
        @(posedge clk_sys) to_pin <= 1'b0;
        set_keys(4'h1, 12'h384);
        wait_out(4'h1, 80);
        set_keys(4'h8, 12'h384);
        wait_out(4'h9, 80);
        wait_out(4'h8, 200);
        wait_out(4'h0, 200);
        hold(4'h0, 100);
        @(posedge clk_sys) to_pin <= 1'b1;
        set_keys(4'h1, 12'h37A);
        wait_out(4'h1, 80);
        hold(4'h1, 400);
        wait_out(4'h0, 600);
        $display("done timeout");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        rst_b = 1'b0;
        ro_pin = 1'b1;
        to_pin = 1'b1;
        key_val = {4{12'h3E8}};
        step(5);
        check("row_oe_b in reset", row_oe_b, 4'hF);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        t_power_up();
        t_integrate();
        t_drift();
        t_rollover();
        t_timeout();
        wrap_up();
    end
endmodule // touch_key_decision_logic_test
`default_nettype wire
